// *** verilog/stl_params.svh ***
// register offsets, bit positions and status codes of the line interface control slice
`ifndef STL_PARAMS_SVH
`define STL_PARAMS_SVH

// register offsets
`define STL_ADDR_W             8
`define STL_OFS_CONTROL        8'h10
`define STL_OFS_STATUS         8'h11

// control register fields
`define STL_BIT_DLOOP          4
`define STL_BIT_B2LOOP         3
`define STL_BIT_B1LOOP         2
`define STL_BIT_FORCE_DEACT    1
`define STL_CONTROL_RESET      8'h00
`define STL_CONTROL_WMASK      8'h1E

// status register fields
`define STL_BIT_FRAME_ERR      7
`define STL_BIT_INFO3          4
`define STL_BIT_INFO1          3
`define STL_READ_NONE          8'h00

// activation state codes
`define STL_CODE_DISABLED      3'h0
`define STL_CODE_G1            3'h1
`define STL_CODE_G2            3'h2
`define STL_CODE_G3            3'h3
`define STL_CODE_G4            3'h4
`define STL_CODE_WAIT_USYNC    3'h5
`define STL_CODE_WAIT_UACT     3'h6
`define STL_CODE_UNUSED        3'h7

`endif

// *** verilog/stl_pkg.sv ***
// types shared by the line interface control slice
`default_nettype none
package stl_pkg;

	// activation state machine
	typedef enum logic [2:0] {
		ST_DISABLED,
		ST_G1,
		ST_WAIT_USYNC,
		ST_G2,
		ST_WAIT_UACT,
		ST_G3,
		ST_G4
	} stl_state_e;

	// line signal sent toward the terminal
	typedef enum logic [1:0] {
		TX_INFO0,
		TX_INFO2,
		TX_INFO4
	} stl_txinfo_e;

endpackage
`default_nettype wire

// *** verilog/stl_loopback_status.sv ***
// loopback control, forced deactivation, activation state machine and line status
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "stl_params.svh"

// How it works
// RULE1: control bit 4 loops D channel back
// RULE2: control bit 3 loops B2 channel back
// RULE3: control bit 2 loops B1 channel back
// RULE4: writing bit 1 forces line deactivation
// RULE5: software writes zero to reserved control bits
// RULE6: status bit 7 sets at once on errors
// RULE7: status bit 7 clears after clean frame
// RULE8: separate latched framing error flag exists
// RULE9: status bit 4 tracks INFO3 presence
// RULE10: status bit 3 tracks INFO1 presence
// RULE11: bits 2..0 give state, never 111
// RULE12: code 000 disabled, sends INFO0
// RULE13: code 001 G1, sends INFO0
// RULE14: code 010 G2, sends INFO2 with ACT
// RULE15: code 011 G3, sends INFO4
// RULE16: code 100 G4, sends INFO0
// RULE17: code 101 waits U sync before INFO2
// RULE18: code 110 waits U activation before INFO4
// RULE19: enable low powers down the interface
// RULE20: control register resets to zero
// RULE21: forced deactivation blocks activation until cleared
module stl_loopback_status #(
	parameter int DATA_W = 8
) (
	input  wire logic                    clk_sys,
	input  wire logic                    reset,
	// register port
	input  wire logic [`STL_ADDR_W-1:0]  reg_addr,
	input  wire logic [7:0]              reg_wdata,
	input  wire logic                    reg_write,
	input  wire logic                    reg_read,
	output logic      [7:0]              reg_rdata,
	// unit level controls and indications
	input  wire logic                    line_interface_enable,
	input  wire logic                    frame_sync_error_latched_clear,
	output logic                         frame_sync_error_latched,
	input  wire logic                    u_sync,
	input  wire logic                    u_act,
	// receiver indications
	input  wire logic                    rx_frame_error,
	input  wire logic                    rx_frame_ok,
	input  wire logic                    rx_info0,
	input  wire logic                    rx_info1,
	input  wire logic                    rx_info3,
	// channel data from terminal and from network side
	input  wire logic                    rx_dchan,
	input  wire logic [DATA_W-1:0]       rx_bchan1,
	input  wire logic [DATA_W-1:0]       rx_bchan2,
	input  wire logic                    net_dchan,
	input  wire logic [DATA_W-1:0]       net_bchan1,
	input  wire logic [DATA_W-1:0]       net_bchan2,
	// toward the terminal
	output logic                         tx_dchan,
	output logic      [DATA_W-1:0]       tx_bchan1,
	output logic      [DATA_W-1:0]       tx_bchan2,
	output var stl_pkg::stl_txinfo_e     tx_info,
	output logic                         tx_act_bit,
	output logic                         line_powered_down
);

	// ------------------------------------------------------------
	// control register
	// ------------------------------------------------------------
	logic [7:0]          control_reg;
	stl_pkg::stl_state_e state_reg;
	stl_pkg::stl_state_e state_next;
	logic                frame_error_reg;
	logic                info0_seen_reg;
	logic [2:0]          state_code;
	logic                sending_active;
	logic                info0_drop;
	logic                force_deact;

	// reserved bits are masked so they always read zero even if software misbehaves
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			control_reg <= `STL_CONTROL_RESET; // RULE20
		else if (reg_write && reg_addr == `STL_OFS_CONTROL)
			control_reg <= reg_wdata & `STL_CONTROL_WMASK; // RULE5
	end

	assign force_deact = control_reg[`STL_BIT_FORCE_DEACT];

	// ------------------------------------------------------------
	// activation state machine
	// ------------------------------------------------------------
	// next state; forced deactivation overrides the G1, wait, G2 and G3 transitions but not disabled to G1 or G4 to G1; disable overrides it
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			stl_pkg::ST_DISABLED:
				if (line_interface_enable)
					state_next = stl_pkg::ST_G1;
			stl_pkg::ST_G1:
				if (rx_info1 && !force_deact) // RULE21
					state_next = stl_pkg::ST_WAIT_USYNC;
			stl_pkg::ST_WAIT_USYNC:
				if (force_deact)
					state_next = stl_pkg::ST_G4; // RULE4
				else if (rx_info0)
					state_next = stl_pkg::ST_G1;
				else if (u_sync)
					state_next = stl_pkg::ST_G2; // RULE17
			stl_pkg::ST_G2:
				if (force_deact)
					state_next = stl_pkg::ST_G4; // RULE4
				else if (rx_info3)
					state_next = stl_pkg::ST_WAIT_UACT;
			stl_pkg::ST_WAIT_UACT:
				if (force_deact)
					state_next = stl_pkg::ST_G4; // RULE4
				else if (!rx_info3)
					state_next = stl_pkg::ST_G2;
				else if (u_act)
					state_next = stl_pkg::ST_G3; // RULE18
			stl_pkg::ST_G3:
				if (force_deact)
					state_next = stl_pkg::ST_G4; // RULE4
				else if (!rx_info3)
					state_next = stl_pkg::ST_G2;
			stl_pkg::ST_G4:
				// the terminal going quiet ends the deactivation
				if (rx_info0)
					state_next = stl_pkg::ST_G1;
			default:
				state_next = stl_pkg::ST_DISABLED;
		endcase
		if (!line_interface_enable)
			state_next = stl_pkg::ST_DISABLED; // RULE19
	end

	always_ff @(posedge clk_sys)
	begin
		if (reset)
			state_reg <= stl_pkg::ST_DISABLED;
		else
			state_reg <= state_next;
	end

	// state code for the status register; 111 has no state behind it
	always_comb
	begin
		case (state_reg)
			stl_pkg::ST_DISABLED:   state_code = `STL_CODE_DISABLED;   // RULE12
			stl_pkg::ST_G1:         state_code = `STL_CODE_G1;         // RULE13
			stl_pkg::ST_G2:         state_code = `STL_CODE_G2;         // RULE14
			stl_pkg::ST_G3:         state_code = `STL_CODE_G3;         // RULE15
			stl_pkg::ST_G4:         state_code = `STL_CODE_G4;         // RULE16
			stl_pkg::ST_WAIT_USYNC: state_code = `STL_CODE_WAIT_USYNC; // RULE17
			stl_pkg::ST_WAIT_UACT:  state_code = `STL_CODE_WAIT_UACT;  // RULE18
			default:                state_code = `STL_CODE_DISABLED;   // RULE11
		endcase
	end

	// line signal toward the terminal, registered to keep the line encoder glitch free
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			tx_info    <= stl_pkg::TX_INFO0;
			tx_act_bit <= 1'b0;
		end
		else
		begin
			case (state_next)
				stl_pkg::ST_G2, stl_pkg::ST_WAIT_UACT:
				begin
					tx_info    <= stl_pkg::TX_INFO2; // RULE14
					tx_act_bit <= 1'b1;
				end
				stl_pkg::ST_G3:
				begin
					tx_info    <= stl_pkg::TX_INFO4; // RULE15
					tx_act_bit <= 1'b1;
				end
				default:
				begin
					tx_info    <= stl_pkg::TX_INFO0; // RULE12
					tx_act_bit <= 1'b0;
				end
			endcase
		end
	end

	// the receiver is held powered down whenever the interface is off
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			line_powered_down <= 1'b1;
		else
			line_powered_down <= !line_interface_enable; // RULE19
	end

	// ------------------------------------------------------------
	// framing error tracking
	// ------------------------------------------------------------
	// loss of signal while we send INFO2 or INFO4 counts as a framing error
	assign sending_active = (tx_info != stl_pkg::TX_INFO0);
	assign info0_drop     = sending_active && rx_info0 && !info0_seen_reg;

	// idle line carries INFO0, so reset to that level to avoid a false edge after reset
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			info0_seen_reg <= 1'b1;
		else
			info0_seen_reg <= rx_info0;
	end

	// live flag; an error in the same cycle as a clean frame end wins
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			frame_error_reg <= 1'b0;
		else if (rx_frame_error || info0_drop)
			frame_error_reg <= 1'b1; // RULE6
		else if (rx_frame_ok)
			frame_error_reg <= 1'b0; // RULE7
	end

	// latched copy for the interrupt flags; only software clears it
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			frame_sync_error_latched <= 1'b0;
		else if (rx_frame_error || info0_drop)
			frame_sync_error_latched <= 1'b1; // RULE8
		else if (frame_sync_error_latched_clear)
			frame_sync_error_latched <= 1'b0;
	end

	// ------------------------------------------------------------
	// remote loopback data path
	// ------------------------------------------------------------
	// each channel chooses independently between network data and its own echo
	always_ff @(posedge clk_sys)
	begin
		if (reset)
		begin
			tx_dchan  <= 1'b1;
			tx_bchan1 <= '0;
			tx_bchan2 <= '0;
		end
		else
		begin
			tx_dchan  <= control_reg[`STL_BIT_DLOOP]  ? rx_dchan  : net_dchan;  // RULE1
			tx_bchan2 <= control_reg[`STL_BIT_B2LOOP] ? rx_bchan2 : net_bchan2; // RULE2
			tx_bchan1 <= control_reg[`STL_BIT_B1LOOP] ? rx_bchan1 : net_bchan1; // RULE3
		end
	end

	// ------------------------------------------------------------
	// register read port
	// ------------------------------------------------------------
	// read data stand for exactly the cycle after the strobe
	always_ff @(posedge clk_sys)
	begin
		if (reset)
			reg_rdata <= `STL_READ_NONE;
		else if (reg_read && reg_addr == `STL_OFS_CONTROL)
			reg_rdata <= control_reg;
		else if (reg_read && reg_addr == `STL_OFS_STATUS)
		begin
			reg_rdata                 <= {5'h00, state_code};
			reg_rdata[`STL_BIT_FRAME_ERR] <= frame_error_reg; // RULE6
			reg_rdata[`STL_BIT_INFO3]     <= rx_info3;        // RULE9
			reg_rdata[`STL_BIT_INFO1]     <= rx_info1;        // RULE10
		end
		else
			reg_rdata <= `STL_READ_NONE;
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);

	AST_DLOOP: assert property ( // RULE1
		control_reg[`STL_BIT_DLOOP] |=> tx_dchan == $past(rx_dchan))
		else $error("D channel not looped back");

	AST_B2LOOP: assert property ( // RULE2
		control_reg[`STL_BIT_B2LOOP] |=> tx_bchan2 == $past(rx_bchan2))
		else $error("B2 channel not looped back");

	AST_B1NORM: assert property ( // RULE3
		!control_reg[`STL_BIT_B1LOOP] |=> tx_bchan1 == $past(net_bchan1))
		else $error("B1 channel not normal");

	AST_FORCE: assert property ( // RULE4
		(force_deact && line_interface_enable
			&& state_reg inside {stl_pkg::ST_G2, stl_pkg::ST_G3})
		|=> state_reg == stl_pkg::ST_G4 ##1 tx_info == stl_pkg::TX_INFO0)
		else $error("forced deactivation ignored");

	AST_RESERVED: assert property ( // RULE5
		(control_reg & ~`STL_CONTROL_WMASK) == 8'h00)
		else $error("reserved control bit set");

	AST_FRAME_SYNC_ERROR_SET: assert property ( // RULE6
		rx_frame_error |=> frame_error_reg && frame_sync_error_latched)
		else $error("frame error not flagged");

	AST_FRAME_SYNC_ERROR_CLR: assert property ( // RULE7
		(rx_frame_ok && !rx_frame_error && !info0_drop) |=> !frame_error_reg)
		else $error("frame error not cleared");

	AST_STATUS_RD: assert property ( // RULE9
		(reg_read && reg_addr == `STL_OFS_STATUS)
		|=> reg_rdata[`STL_BIT_INFO3] == $past(rx_info3)
			&& reg_rdata[2:0] == $past(state_code))
		else $error("status read wrong");

	AST_NO_111: assert property ( // RULE11
		state_code != `STL_CODE_UNUSED)
		else $error("unused state code reported");

	AST_DISABLE: assert property ( // RULE19
		!line_interface_enable |=> state_code == `STL_CODE_DISABLED
			##1 tx_info == stl_pkg::TX_INFO0)
		else $error("disabled interface not idle");

	AST_HOLD_USYNC: assert property ( // RULE17
		(state_reg == stl_pkg::ST_WAIT_USYNC && !u_sync) |=> state_reg != stl_pkg::ST_G2)
		else $error("INFO2 sent before U sync");

	AST_HOLD_UACT: assert property ( // RULE18
		(state_reg == stl_pkg::ST_WAIT_UACT && !u_act) |=> state_reg != stl_pkg::ST_G3)
		else $error("INFO4 sent before U activation");

	AST_G1_HOLD: assert property ( // RULE21
		(state_reg == stl_pkg::ST_G1 && force_deact && line_interface_enable)
		|=> state_reg == stl_pkg::ST_G1)
		else $error("activation accepted while forced off");

	COV_ACTIVATE: cover property (state_reg == stl_pkg::ST_WAIT_UACT ##1 state_reg == stl_pkg::ST_G3);
	COV_FORCE:    cover property (state_reg == stl_pkg::ST_G3 ##1 state_reg == stl_pkg::ST_G4);
	COV_ERROR:    cover property (frame_error_reg ##[1:20] !frame_error_reg);
	COV_LOOP:     cover property (control_reg[`STL_BIT_DLOOP] && control_reg[`STL_BIT_B1LOOP]);

endmodule
`default_nettype wire

// *** testbench/stl_te_model.sv ***
// terminal equipment model: line signal levels and per-cycle channel data
`timescale 1ns/1ps
`default_nettype none
module stl_te_model #(
	parameter int DATA_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic [1:0]        sig_sel,
	output logic                   rx_info0,
	output logic                   rx_info1,
	output logic                   rx_info3,
	output logic                   rx_dchan,
	output logic      [DATA_W-1:0] rx_bchan1,
	output logic      [DATA_W-1:0] rx_bchan2
);
	logic [DATA_W-1:0] cnt_reg = '0;

	// line signal: 0 idle INFO0, 1 INFO1, 2 INFO3, 3 silent
	assign rx_info0 = (sig_sel == 2'h0);
	assign rx_info1 = (sig_sel == 2'h1);
	assign rx_info3 = (sig_sel == 2'h2);

	// data changes every cycle so a stale loop path cannot pass for a live one
	always_ff @(posedge clk_sys)
	begin
		cnt_reg <= cnt_reg + 1'b1;
	end
	assign rx_dchan  = cnt_reg[0];
	assign rx_bchan1 = cnt_reg;
	assign rx_bchan2 = ~cnt_reg;
endmodule
`default_nettype wire

// *** testbench/tb.sv ***
// self-checking bench: registers, activation walk, loopback, framing flags, forced deactivation
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic       clk_sys = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic       reg_write = 1'b0;
	logic       reg_read = 1'b0;
	logic       enable = 1'b0;
	logic       flag_clear = 1'b0;
	logic       u_sync = 1'b0;
	logic       u_act = 1'b0;
	logic       frame_error = 1'b0;
	logic       frame_ok = 1'b0;
	logic [1:0] sig_sel = 2'h0;
	logic [7:0] reg_rdata, rx_b1, rx_b2, tx_b1, tx_b2;
	logic       flag_latched, info0, info1, info3, rx_d, tx_d, powered_down, act_bit;
	stl_pkg::stl_txinfo_e tx_info;
	int         fails = 0;
	int         checks = 0;

	// clock and watchdog; the whole run needs well under 1000 cycles
	initial forever #5 clk_sys = ~clk_sys;
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end

	stl_te_model u_stl_te_model (.clk_sys(clk_sys), .sig_sel(sig_sel), .rx_info0(info0),
		.rx_info1(info1), .rx_info3(info3), .rx_dchan(rx_d), .rx_bchan1(rx_b1),
		.rx_bchan2(rx_b2));

	// network-side data are constants so a looped channel is told apart from it
	stl_loopback_status u_stl_loopback_status (.clk_sys(clk_sys), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .line_interface_enable(enable),
		.frame_sync_error_latched_clear(flag_clear), .frame_sync_error_latched(flag_latched),
		.u_sync(u_sync), .u_act(u_act), .rx_frame_error(frame_error), .rx_frame_ok(frame_ok),
		.rx_info0(info0), .rx_info1(info1), .rx_info3(info3), .rx_dchan(rx_d),
		.rx_bchan1(rx_b1), .rx_bchan2(rx_b2), .net_dchan(1'b0), .net_bchan1(8'h5A),
		.net_bchan2(8'hC3), .tx_dchan(tx_d), .tx_bchan1(tx_b1), .tx_bchan2(tx_b2),
		.tx_info(tx_info), .tx_act_bit(act_bit), .line_powered_down(powered_down));

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		chk8(reg_rdata, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// line side as {act bit, tx info}
	task automatic chk_line(input logic [7:0] exp);
		chk8({5'h00, act_bit, tx_info}, exp);
	endtask

	task automatic t_reset();
		rd_chk(8'h10, 8'h00);
		rd_chk(8'h11, 8'h00);
		chk_line(8'h00);
		chk8({7'h00, powered_down}, 8'h01);
		wr(8'h11, 8'hFF);
		rd_chk(8'h11, 8'h00);
		rd_chk(8'h20, 8'h00);
		$display("test reset done");
	endtask

	task automatic t_activate();
		@(posedge clk_sys) enable <= 1'b1;
		cyc(3);
		rd_chk(8'h11, 8'h01);
		chk8({7'h00, powered_down}, 8'h00);
		@(posedge clk_sys) sig_sel <= 2'h1;
		cyc(3);
		rd_chk(8'h11, 8'h0D);
		chk_line(8'h00);
		@(posedge clk_sys) u_sync <= 1'b1;
		cyc(3);
		rd_chk(8'h11, 8'h0A);
		chk_line(8'h05);
		@(posedge clk_sys) sig_sel <= 2'h2;
		cyc(3);
		rd_chk(8'h11, 8'h16);
		chk_line(8'h05);
		@(posedge clk_sys) u_act <= 1'b1;
		cyc(3);
		rd_chk(8'h11, 8'h13);
		chk_line(8'h06);
		$display("test activate done");
	endtask

	task automatic chk_loop(input logic [7:0] ctl);
		logic       d;
		logic [7:0] b1;
		logic [7:0] b2;
		wr(8'h10, ctl);
		repeat (4)
		begin
			@(negedge clk_sys);
			d  = rx_d;
			b1 = rx_b1;
			b2 = rx_b2;
			@(negedge clk_sys);
			chk8({7'h00, tx_d}, ctl[4] ? {7'h00, d} : 8'h00);
			chk8(tx_b2, ctl[3] ? b2 : 8'hC3);
			chk8(tx_b1, ctl[2] ? b1 : 8'h5A);
		end
	endtask

	task automatic t_loop();
		chk_loop(8'h14);
		chk_loop(8'h08);
		rd_chk(8'h10, 8'h08);
		chk_loop(8'h00);
		$display("test loopback done");
	endtask

	task automatic t_frame();
		@(posedge clk_sys) frame_error <= 1'b1;
		@(posedge clk_sys) frame_error <= 1'b0;
		cyc(2);
		rd_chk(8'h11, 8'h93);
		@(posedge clk_sys) frame_ok <= 1'b1;
		@(posedge clk_sys) frame_ok <= 1'b0;
		cyc(2);
		rd_chk(8'h11, 8'h13);
		chk8({7'h00, flag_latched}, 8'h01);
		@(posedge clk_sys) flag_clear <= 1'b1;
		@(posedge clk_sys) flag_clear <= 1'b0;
		cyc(2);
		chk8({7'h00, flag_latched}, 8'h00);
		$display("test framing done");
	endtask

	task automatic t_force();
		@(posedge clk_sys) {u_sync, u_act} <= 2'h0;
		wr(8'h10, 8'h02);
		cyc(3);
		rd_chk(8'h11, 8'h14);
		chk_line(8'h00);
		@(posedge clk_sys) sig_sel <= 2'h0;
		cyc(3);
		rd_chk(8'h11, 8'h01);
		@(posedge clk_sys) sig_sel <= 2'h1;
		cyc(3);
		rd_chk(8'h11, 8'h09);
		wr(8'h10, 8'h00);
		cyc(3);
		rd_chk(8'h11, 8'h0D);
		@(posedge clk_sys) u_sync <= 1'b1;
		cyc(3);
		@(posedge clk_sys) sig_sel <= 2'h0;
		cyc(3);
		rd_chk(8'h11, 8'h82);
		chk8({7'h00, flag_latched}, 8'h01);
		@(posedge clk_sys) frame_ok <= 1'b1;
		@(posedge clk_sys) frame_ok <= 1'b0;
		enable <= 1'b0;
		cyc(3);
		rd_chk(8'h11, 8'h00);
		chk_line(8'h00);
		chk8({7'h00, powered_down}, 8'h01);
		$display("test force done");
	endtask

	task automatic wrap_up();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// main sequence: reset held for 12 cycles, then the scenarios in line order
	initial
	begin
		repeat (12) @(posedge clk_sys);
		reset <= 1'b0;
		t_reset();
		t_activate();
		t_loop();
		t_frame();
		t_force();
		wrap_up();
	end
endmodule
`default_nettype wire
